// file: src/pfs_status_mux.sv
// per-function status multiplexer with request filter and error reporting
//
// Summary of operation
// - selector takes only 000b, 001b, 011b, 100b, 101b; others reserved.
// - a 16-bit status word follows the selector and the function index.
// - page 000b bit 0 is I/O enable; endpoint refuses I/O with UR if clear.
// - page 000b bit 1 is memory enable; endpoint refuses memory with UR if clear.
// - bit 3 is interrupt disable; no INTx is asserted while it is set.
// - bit 4 system error enable; non-fatal and fatal errors report if it or device controls allow.
// - root or switch forwards secondary error messages only with system error enable.
// - bit 6 shows end-to-end CRC checking enabled by the host.
// - bit 7 shows end-to-end CRC generation enabled by the host.
// - page 001b bits 0 to 3 show sticky error detection, logged always.
// - page 001b bits 10 to 8 hold max payload, 128 to 4096 bytes.
`timescale 1ns/1ps
`default_nettype none
module pfs_status_mux (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // port role: 1 for root or switch, 0 for endpoint
    input wire logic isRootSwitch,
    // status selector and function index
    input wire logic [2:0] statusSel,
    input wire logic [pfs_pkg::FUNC_W-1:0] funcNum,
    // per-function configuration
    input wire pfs_pkg::pfs_ctrl_t [pfs_pkg::NUM_FUNC-1:0] funcCtrl,
    // per-function error events and sticky clears
    input wire pfs_pkg::pfs_err_t [pfs_pkg::NUM_FUNC-1:0] errEvt,
    input wire pfs_pkg::pfs_err_t [pfs_pkg::NUM_FUNC-1:0] errClr,
    // incoming request for filtering
    input wire pfs_pkg::pfs_req_t rxReq,
    // legacy interrupt request per function
    input wire logic [pfs_pkg::NUM_FUNC-1:0] intxReq,
    // secondary-side error messages to forward (root or switch)
    input wire pfs_pkg::pfs_msg_t [pfs_pkg::NUM_FUNC-1:0] fwdMsg,
    // status word
    output logic [15:0] statusData,
    output logic statusSelBad,
    // request filter verdict
    output logic reqAccept,
    output logic reqUnsupported,
    // legacy interrupt lines
    output logic [pfs_pkg::NUM_FUNC-1:0] intxOut,
    // error message strobes
    output pfs_pkg::pfs_msg_t errMsg
);
    import pfs_pkg::*;

    // ------------------------------------------------------------------
    // sticky error flags per function
    // ------------------------------------------------------------------
    pfs_err_t [NUM_FUNC-1:0] errSticky;

    // one flag set per function
    for (genvar f = 0; f < NUM_FUNC; f++) begin : g_func
        pfs_func_state u_state (
            .clk(clk),
            .rst_n(rst_n),
            .errEvt(errEvt[f]),
            .errClr(errClr[f]),
            .errSticky(errSticky[f])
        );
    end

    // ------------------------------------------------------------------
    // status word
    // ------------------------------------------------------------------
    logic [15:0] stat_q;
    logic [15:0] stat_d;
    logic selBad_q;
    logic selBad_d;
    pfs_ctrl_t selCtrl;
    pfs_err_t selErr;

    // choose the page for the addressed function
    always_comb begin
        selCtrl = funcCtrl[funcNum];
        selErr = errSticky[funcNum];
        stat_d = STAT_RESET;
        selBad_d = 1'b0;
        case (statusSel)
            SEL_CMD: begin
                stat_d[CMD_IO_BIT] = selCtrl.ioEn;
                stat_d[CMD_MEM_BIT] = selCtrl.memEn;
                stat_d[CMD_BME_BIT] = selCtrl.busMasterEn;
                stat_d[CMD_INTD_BIT] = selCtrl.intxDisable;
                stat_d[CMD_SERR_BIT] = selCtrl.serrEn;
                stat_d[CMD_BSERR_BIT] = selCtrl.bridgeSerrEn;
                stat_d[CMD_ECHK_BIT] = selCtrl.ecrcCheckEn;
                stat_d[CMD_EGEN_BIT] = selCtrl.ecrcGenEn;
            end
            SEL_DEV: begin
                stat_d[DEV_CORR_BIT] = selErr.corr;
                stat_d[DEV_NFAT_BIT] = selErr.nonFatal;
                stat_d[DEV_FAT_BIT] = selErr.fatal;
                stat_d[DEV_UR_BIT] = selErr.ur;
                stat_d[DEV_CORR_EN_BIT] = selCtrl.corrRptEn;
                stat_d[DEV_NFAT_EN_BIT] = selCtrl.nonFatalRptEn;
                stat_d[DEV_FAT_EN_BIT] = selCtrl.fatalRptEn;
                stat_d[DEV_UR_EN_BIT] = selCtrl.urRptEn;
                stat_d[DEV_MPS_LSB +: 3] = selCtrl.maxPayload;
            end
            SEL_PAGE3, SEL_PAGE4, SEL_PAGE5: begin
                stat_d = STAT_RESET; // pages not carried here read zero
            end
            default: begin
                selBad_d = 1'b1;
            end
        endcase
    end

    // register the status word
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stat_q <= STAT_RESET;
            selBad_q <= 1'b0;
        end else begin
            stat_q <= stat_d;
            selBad_q <= selBad_d;
        end
    end

    // ------------------------------------------------------------------
    // request filter
    // ------------------------------------------------------------------
    logic acc_q;
    logic acc_d;
    logic ur_q;
    logic ur_d;
    pfs_ctrl_t reqCtrl;

    // endpoint refuses disabled spaces; root or switch passes all through
    always_comb begin
        reqCtrl = funcCtrl[rxReq.func];
        acc_d = 1'b0;
        ur_d = 1'b0;
        if (rxReq.valid) begin
            if (isRootSwitch) begin
                acc_d = 1'b1;
            end else if (rxReq.isIo) begin
                acc_d = reqCtrl.ioEn;
                ur_d = !reqCtrl.ioEn;
            end else if (rxReq.isMem) begin
                acc_d = reqCtrl.memEn;
                ur_d = !reqCtrl.memEn;
            end else begin
                acc_d = 1'b1; // other kinds are not filtered here
            end
        end
    end

    // register the verdict
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc_q <= 1'b0;
            ur_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            ur_q <= ur_d;
        end
    end

    // ------------------------------------------------------------------
    // interrupts and error messages
    // ------------------------------------------------------------------
    logic [NUM_FUNC-1:0] intx_q;
    logic [NUM_FUNC-1:0] intx_d;
    pfs_msg_t msg_q;
    pfs_msg_t msg_d;
    pfs_err_t evt;

    // gate interrupts and merge error messages over all functions
    always_comb begin
        msg_d = '0;
        evt = '0;
        for (int f = 0; f < NUM_FUNC; f++) begin
            evt = errEvt[f];
            intx_d[f] = intxReq[f] && !funcCtrl[f].intxDisable;
            msg_d.corr = msg_d.corr | (evt.corr & funcCtrl[f].corrRptEn);
            msg_d.nonFatal = msg_d.nonFatal
                | ((evt.nonFatal | evt.ur) & (funcCtrl[f].serrEn
                | funcCtrl[f].nonFatalRptEn));
            msg_d.fatal = msg_d.fatal
                | (evt.fatal & (funcCtrl[f].serrEn | funcCtrl[f].fatalRptEn));
            if (isRootSwitch) begin
                msg_d.nonFatal = msg_d.nonFatal
                    | (fwdMsg[f].nonFatal & funcCtrl[f].serrEn);
                msg_d.fatal = msg_d.fatal
                    | (fwdMsg[f].fatal & funcCtrl[f].serrEn);
            end
        end
    end

    // register interrupt lines and message strobes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            intx_q <= '0;
            msg_q <= '0;
        end else begin
            intx_q <= intx_d;
            msg_q <= msg_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign statusData = stat_q;
    assign statusSelBad = selBad_q;
    assign reqAccept = acc_q;
    assign reqUnsupported = ur_q;
    assign intxOut = intx_q;
    assign errMsg = msg_q;

endmodule : pfs_status_mux
`default_nettype wire

// file: pkg/pfs_pkg.sv
// package for the per-function status multiplexer
package pfs_pkg;

    // ------------------------------------------------------------------
    // sizes and selector codes
    // ------------------------------------------------------------------
    localparam int NUM_FUNC = 2;
    localparam int FUNC_W = 1;
    localparam int STAT_W = 16;
    localparam logic [2:0] SEL_CMD = 3'h0;
    localparam logic [2:0] SEL_DEV = 3'h1;
    localparam logic [2:0] SEL_PAGE3 = 3'h3;
    localparam logic [2:0] SEL_PAGE4 = 3'h4;
    localparam logic [2:0] SEL_PAGE5 = 3'h5;
    localparam logic [2:0] MPS_MAX = 3'h5;
    localparam logic [15:0] STAT_RESET = 16'h0000;

    // ------------------------------------------------------------------
    // field positions, command page
    // ------------------------------------------------------------------
    localparam int CMD_IO_BIT = 0;
    localparam int CMD_MEM_BIT = 1;
    localparam int CMD_BME_BIT = 2;
    localparam int CMD_INTD_BIT = 3;
    localparam int CMD_SERR_BIT = 4;
    localparam int CMD_BSERR_BIT = 5;
    localparam int CMD_ECHK_BIT = 6;
    localparam int CMD_EGEN_BIT = 7;

    // ------------------------------------------------------------------
    // field positions, device page
    // ------------------------------------------------------------------
    localparam int DEV_CORR_BIT = 0;
    localparam int DEV_NFAT_BIT = 1;
    localparam int DEV_FAT_BIT = 2;
    localparam int DEV_UR_BIT = 3;
    localparam int DEV_CORR_EN_BIT = 4;
    localparam int DEV_NFAT_EN_BIT = 5;
    localparam int DEV_FAT_EN_BIT = 6;
    localparam int DEV_UR_EN_BIT = 7;
    localparam int DEV_MPS_LSB = 8;

    // per-function configuration controls
    typedef struct packed {
        logic ioEn;
        logic memEn;
        logic busMasterEn;
        logic intxDisable;
        logic serrEn;
        logic bridgeSerrEn;
        logic ecrcCheckEn;
        logic ecrcGenEn;
        logic corrRptEn;
        logic nonFatalRptEn;
        logic fatalRptEn;
        logic urRptEn;
        logic [2:0] maxPayload;
    } pfs_ctrl_t;

    // per-function error events, one-cycle pulses
    typedef struct packed {
        logic corr;
        logic nonFatal;
        logic fatal;
        logic ur;
    } pfs_err_t;

    // incoming request to be filtered
    typedef struct packed {
        logic valid;
        logic isIo;
        logic isMem;
        logic [FUNC_W-1:0] func;
    } pfs_req_t;

    // error message strobes toward the link
    typedef struct packed {
        logic corr;
        logic nonFatal;
        logic fatal;
    } pfs_msg_t;

endpackage : pfs_pkg

// file: src/pfs_func_state.sv
// per-function sticky error detected flags
`timescale 1ns/1ps
`default_nettype none
module pfs_func_state (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // error events and clears
    input wire pfs_pkg::pfs_err_t errEvt,
    input wire pfs_pkg::pfs_err_t errClr,
    // sticky flags
    output var pfs_pkg::pfs_err_t errSticky
);
    import pfs_pkg::*;

    pfs_err_t stick_q;
    pfs_err_t stick_d;

    // flags log regardless of reporting enables; set beats clear
    always_comb begin
        stick_d = (stick_q & ~errClr) | errEvt;
    end

    // register the flags
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stick_q <= '0;
        end else begin
            stick_q <= stick_d;
        end
    end

    assign errSticky = stick_q;

endmodule : pfs_func_state
`default_nettype wire

// file: dv/pfs_user_model.sv
// user-side model choosing status pages and configuration
`timescale 1ns/1ps
`default_nettype none
module pfs_user_model (
    // random word and reserved-code mode
    input wire logic [63:0] rnd,
    input wire logic badSel,
    // status request and configuration
    output logic [2:0] statusSel,
    output logic [pfs_pkg::FUNC_W-1:0] funcNum,
    output var pfs_pkg::pfs_ctrl_t [pfs_pkg::NUM_FUNC-1:0] funcCtrl
);
    import pfs_pkg::*;
    logic [2:0] pick;
    // legal payload codes always; legal pages unless a reserved page is wanted
    always_comb begin
        pick = 3'(rnd[63:61] % 3'h5);
        statusSel = badSel ? rnd[63:61] : (pick > 3'h1 ? pick + 3'h1 : pick);
        funcNum = rnd[60 -: FUNC_W];
        funcCtrl = rnd[$bits(funcCtrl)-1:0];
        for (int f = 0; f < NUM_FUNC; f++) begin
            funcCtrl[f].maxPayload = 3'(funcCtrl[f].maxPayload % 3'h6);
        end
    end
endmodule : pfs_user_model
`default_nettype wire

// file: dv/pfs_status_mux_asserts.sv
// port checks for the status multiplexer
`timescale 1ns/1ps
`default_nettype none
module pfs_status_mux_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // inputs watched
    input wire logic isRootSwitch,
    input wire logic [2:0] statusSel,
    input wire logic [pfs_pkg::FUNC_W-1:0] funcNum,
    input wire pfs_pkg::pfs_ctrl_t [pfs_pkg::NUM_FUNC-1:0] funcCtrl,
    input wire pfs_pkg::pfs_err_t [pfs_pkg::NUM_FUNC-1:0] errEvt,
    input wire pfs_pkg::pfs_req_t rxReq,
    input wire logic [pfs_pkg::NUM_FUNC-1:0] intxReq,
    // outputs watched
    input wire logic [15:0] statusData,
    input wire logic statusSelBad,
    input wire logic reqAccept,
    input wire logic reqUnsupported,
    input wire logic [pfs_pkg::NUM_FUNC-1:0] intxOut,
    input wire pfs_pkg::pfs_msg_t errMsg
);
    import pfs_pkg::*;
    pfs_ctrl_t cs, cr;
    logic [7:0] p0;
    logic [NUM_FUNC-1:0] dis;
    logic fatOk;
    // selected controls and expected gates
    always_comb begin
        cs = funcCtrl[funcNum];
        cr = funcCtrl[rxReq.func];
        p0 = {cs.ecrcGenEn, cs.ecrcCheckEn, cs.bridgeSerrEn, cs.serrEn,
            cs.intxDisable, cs.busMasterEn, cs.memEn, cs.ioEn};
        fatOk = 1'b0;
        for (int f = 0; f < NUM_FUNC; f++) begin
            dis[f] = funcCtrl[f].intxDisable;
            fatOk |= errEvt[f].fatal & (funcCtrl[f].serrEn | funcCtrl[f].fatalRptEn);
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sel_reserved_a: assert property ($past(rst_n) && statusSel inside {3'h2, 3'h6, 3'h7}
        |=> statusSelBad && statusData == 16'h0000) else $error("reserved page not flagged");
    cmd_bits_a: assert property ($past(rst_n) && statusSel == SEL_CMD
        |=> statusData[7:0] == $past(p0)) else $error("command page bits wrong");
    cmd_upper_a: assert property ($past(rst_n) && statusSel == SEL_CMD
        |=> statusData[15:8] == 8'h00) else $error("command upper byte not zero");
    dev_payload_a: assert property ($past(rst_n) && statusSel == SEL_DEV
        |=> statusData[10:8] == $past(cs.maxPayload)) else $error("payload code wrong");
    io_filter_a: assert property ($past(rst_n) && rxReq.valid && rxReq.isIo
        && !isRootSwitch && !cr.ioEn |=> reqUnsupported && !reqAccept)
        else $error("io not refused");
    mem_filter_a: assert property ($past(rst_n) && rxReq.valid && rxReq.isMem
        && !rxReq.isIo && !isRootSwitch
        |=> reqAccept == $past(cr.memEn) && reqUnsupported != reqAccept)
        else $error("memory filter wrong");
    intx_gate_a: assert property ($past(rst_n) |-> intxOut == $past(intxReq & ~dis))
        else $error("interrupt not gated");
    fatal_msg_a: assert property ($past(rst_n) && !$past(isRootSwitch)
        |-> errMsg.fatal == $past(fatOk)) else $error("fatal message wrong");
    sticky_log_a: assert property ($past(rst_n) && errEvt[0].corr
        && !funcCtrl[0].corrRptEn ##1 statusSel == SEL_DEV && funcNum == '0
        |=> statusData[0]) else $error("error not logged");
endmodule : pfs_status_mux_asserts
bind pfs_status_mux pfs_status_mux_asserts chk (
    .clk(clk),
    .rst_n(rst_n),
    .isRootSwitch(isRootSwitch),
    .statusSel(statusSel),
    .funcNum(funcNum),
    .funcCtrl(funcCtrl),
    .errEvt(errEvt),
    .rxReq(rxReq),
    .intxReq(intxReq),
    .statusData(statusData),
    .statusSelBad(statusSelBad),
    .reqAccept(reqAccept),
    .reqUnsupported(reqUnsupported),
    .intxOut(intxOut),
    .errMsg(errMsg)
);
`default_nettype wire

// file: dv/tb.sv
// random self-checking bench for the status multiplexer
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pfs_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic isRootSwitch = 1'b0;
    logic badSel = 1'b0;
    logic [63:0] rnd = 64'h0;
    logic [31:0] seed = 32'h0000_7137;
    logic [2:0] statusSel;
    logic [FUNC_W-1:0] funcNum;
    pfs_ctrl_t [NUM_FUNC-1:0] funcCtrl;
    pfs_err_t [NUM_FUNC-1:0] errEvt = '0, errClr = '0;
    pfs_req_t rxReq = '0;
    logic [NUM_FUNC-1:0] intxReq = '0, intxOut;
    pfs_msg_t [NUM_FUNC-1:0] fwdMsg = '0;
    logic [15:0] statusData;
    logic statusSelBad, reqAccept, reqUnsupported;
    pfs_msg_t errMsg;
    pfs_err_t stk [NUM_FUNC];
    int n_mismatch = 0;
    int num_checks = 0;
    // user side and unit under test
    pfs_user_model user (.rnd(rnd), .badSel(badSel), .statusSel(statusSel),
        .funcNum(funcNum), .funcCtrl(funcCtrl));
    pfs_status_mux uut (.clk(clk), .rst_n(rst_n), .isRootSwitch(isRootSwitch),
        .statusSel(statusSel), .funcNum(funcNum), .funcCtrl(funcCtrl), .errEvt(errEvt),
        .errClr(errClr), .rxReq(rxReq), .intxReq(intxReq), .fwdMsg(fwdMsg),
        .statusData(statusData), .statusSelBad(statusSelBad), .reqAccept(reqAccept),
        .reqUnsupported(reqUnsupported), .intxOut(intxOut), .errMsg(errMsg));
    initial forever #5 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    function automatic logic [15:0] expWord(input pfs_ctrl_t c, input pfs_err_t k);
        case (statusSel)
            SEL_CMD: return {8'h00, c.ecrcGenEn, c.ecrcCheckEn, c.bridgeSerrEn, c.serrEn,
                c.intxDisable, c.busMasterEn, c.memEn, c.ioEn};
            SEL_DEV: return {5'h00, c.maxPayload, c.urRptEn, c.fatalRptEn, c.nonFatalRptEn,
                c.corrRptEn, k.ur, k.fatal, k.nonFatal, k.corr};
            default: return 16'h0000;
        endcase
    endfunction : expWord
    function automatic pfs_msg_t expMsg();
        pfs_msg_t m = '0;
        pfs_ctrl_t c;
        for (int f = 0; f < NUM_FUNC; f++) begin
            c = funcCtrl[f];
            m.corr |= errEvt[f].corr & c.corrRptEn;
            m.nonFatal |= (errEvt[f].nonFatal | errEvt[f].ur) & (c.serrEn | c.nonFatalRptEn);
            m.fatal |= errEvt[f].fatal & (c.serrEn | c.fatalRptEn);
            m.nonFatal |= isRootSwitch & fwdMsg[f].nonFatal & c.serrEn;
            m.fatal |= isRootSwitch & fwdMsg[f].fatal & c.serrEn;
        end
        return m;
    endfunction : expMsg
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // reset with event inputs quiet, model flags cleared
    task automatic do_reset(input int n);
        @(negedge clk);
        rst_n = 1'b0;
        {errEvt, errClr, rxReq, fwdMsg, intxReq} = '0;
        repeat (n) @(negedge clk);
        chk("reset", 16'h0000, statusData | 16'(errMsg)
            | 16'({statusSelBad, reqAccept, reqUnsupported, intxOut}));
        rst_n = 1'b1;
        stk = '{default: '0};
        @(posedge clk);
    endtask : do_reset
    // random traffic, every output compared one edge later
    task automatic run(input string name, input int n, input logic bad,
        input logic corner = 1'b0);
        logic [15:0] ew;
        pfs_msg_t em;
        logic [1:0] er;
        logic [NUM_FUNC-1:0] ei;
        pfs_ctrl_t c;
        pfs_req_t q;
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            badSel = bad;
            seed = xs(seed);
            rnd = {rnd[31:0], seed};
            if (corner) rnd[63:60] = 4'h2; // device page of function 0
            isRootSwitch = seed[31];
            seed = xs(seed);
            errEvt = seed[7:0] & seed[15:8];
            errClr = seed[23:16] & seed[31:24];
            if (corner) errClr |= errEvt; // set and clear in one cycle
            seed = xs(seed);
            q = seed[3:0];
            q.isMem = q.isMem & ~q.isIo;
            rxReq = q;
            intxReq = seed[4 +: NUM_FUNC];
            fwdMsg = seed[8 +: $bits(fwdMsg)];
            #1;
            // user logic forwards secondary errors only with bridge enable
            for (int f = 0; f < NUM_FUNC; f++) begin
                if (!funcCtrl[f].bridgeSerrEn) fwdMsg[f] = '0;
            end
            c = funcCtrl[q.func];
            ew = expWord(funcCtrl[funcNum], stk[funcNum]);
            er[0] = q.valid & ~isRootSwitch & (q.isIo & ~c.ioEn | q.isMem & ~c.memEn);
            er[1] = q.valid & ~er[0];
            for (int f = 0; f < NUM_FUNC; f++) ei[f] = intxReq[f] & ~funcCtrl[f].intxDisable;
            em = expMsg();
            @(posedge clk);
            #1;
            chk("word", ew, statusData);
            chk("bad", 16'(statusSel inside {3'h2, 3'h6, 3'h7}), 16'(statusSelBad));
            chk("filter", 16'(er), {14'h0, reqAccept, reqUnsupported});
            chk("intx", 16'(ei), 16'(intxOut));
            chk("msg", 16'(em), 16'(errMsg));
            for (int f = 0; f < NUM_FUNC; f++) stk[f] = stk[f] & ~errClr[f] | errEvt[f];
        end
        $display("test %s done", name);
    endtask : run
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out
    // main sequence
    initial begin
        do_reset(10);
        run("legal", 300, 1'b0);
        run("corner", 50, 1'b0, 1'b1);
        run("reserved", 100, 1'b1);
        do_reset(2);
        run("again", 100, 1'b0);
        close_out();
    end
    // watchdog
    initial begin
        #20000;
        n_mismatch++;
        close_out();
    end
endmodule : tb
`default_nettype wire
